// ### rtl/ldc_cmd_decode.sv
`timescale 1ns/10ps
`include "ldc_defs.svh"

module ldc_cmd_decode
	import ldc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic cmd_valid,
	input wire logic [11:0] cmd_code,
	output ldc_cmd_kind_t last_kind,
	output ldc_cmd_pulse_t pulse
);

	// ****************************************************************
	// Code to command kind
	// ****************************************************************
	function automatic ldc_cmd_kind_t classify(input logic [11:0] code);
		ldc_cmd_kind_t k;
		k = CMD_NULL;
		unique case (code)
			`LDC_CODE_GLOBAL_RESET: k = CMD_GLOBAL_RESET;
			`LDC_CODE_SELF_TEST: k = CMD_SELF_TEST;
			`LDC_CODE_NEIGHBOUR_SHORT: k = CMD_NEIGHBOUR_SHORT;
			`LDC_CODE_NEGATE_TOGGLE: k = CMD_NEGATE_TOGGLE;
			`LDC_CODE_READ_STATUS: k = CMD_READ_STATUS;
			`LDC_CODE_READ_CONFIG: k = CMD_READ_CONFIG;
			`LDC_CODE_READ_GRAYSCALE: k = CMD_READ_GRAYSCALE;
			`LDC_CODE_ERROR_CLEAR: k = CMD_ERROR_CLEAR;
			default: k = CMD_NULL;
		endcase
		return k;
	endfunction

	ldc_cmd_kind_t kind_w;
	ldc_cmd_kind_t last_kind_r;
	ldc_cmd_pulse_t pulse_r;
	ldc_cmd_pulse_t pulse_nxt;

	assign kind_w = classify(cmd_code);

	always_comb begin
		pulse_nxt = '0;
		pulse_nxt.read_target = RB_NONE;
		if (cmd_valid) begin
			pulse_nxt.global_reset = (kind_w == CMD_GLOBAL_RESET);
			pulse_nxt.error_clear = (kind_w == CMD_ERROR_CLEAR);
			pulse_nxt.self_test = (kind_w == CMD_SELF_TEST);
			pulse_nxt.neighbour_pin_short =
				(kind_w == CMD_NEIGHBOUR_SHORT);
			pulse_nxt.negate_toggle = (kind_w == CMD_NEGATE_TOGGLE);
			unique case (kind_w)
				CMD_READ_STATUS: begin
					pulse_nxt.read_select = 1'b1;
					pulse_nxt.read_target = RB_STATUS;
				end
				CMD_READ_CONFIG: begin
					pulse_nxt.read_select = 1'b1;
					pulse_nxt.read_target = RB_CONFIG;
				end
				CMD_READ_GRAYSCALE: begin
					pulse_nxt.read_select = 1'b1;
					pulse_nxt.read_target = RB_GRAYSCALE;
				end
				default: begin
					pulse_nxt.read_select = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pulse_r <= '0;
			last_kind_r <= CMD_NULL;
		end else begin
			pulse_r <= pulse_nxt;
			if (cmd_valid) begin
				last_kind_r <= kind_w;
			end
		end
	end

	assign pulse = pulse_r;
	assign last_kind = last_kind_r;

endmodule

// ### rtl/ldc_config_regs.sv
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`include "ldc_defs.svh"


module ldc_config_regs
	import ldc_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output ldc_cfg_t cfg,
	output logic [1:0] negate_check_bit,
	output ldc_readback_t readback_select,
	output logic detector_self_test_start,
	output logic neighbour_pin_short_start,
	output logic error_clear,
	output logic global_reset
);

	// ****************************************************************
	// Elaboration checks
	// ****************************************************************
	if (ADDR_W < 7) begin : g_addr_chk
		$error("ADDR_W must be at least 7");
	end

	// ****************************************************************
	// Word geometry checks
	// ****************************************************************

	if (`LDC_WORD_BITS != 32 * `LDC_BUS_WORDS) begin : g_tile_chk
		$error("Word width must be a whole number of bus words");
	end

	if (`LDC_BUS_WORDS > 15) begin : g_index_chk
		$error("Status index must fit the four-bit word index");
	end

	if (`LDC_STATUS_IDX != `LDC_BUS_WORDS) begin : g_status_chk
		$error("Status must sit just above the configuration word");
	end

	if (`LDC_CMD_WORD_IDX != `LDC_BUS_WORDS - 1) begin : g_cmd_word_chk
		$error("Command must live in the top bus word");
	end

	if (`LDC_CMD_MSB != `LDC_WORD_BITS - 1) begin : g_cmd_top_chk
		$error("Command field must end the word");
	end

	if (`LDC_CMD_MSB - `LDC_CMD_LSB != 11) begin : g_cmd_width_chk
		$error("Command field must be twelve bits");
	end

	if (`LDC_CMD_LSB < 32 * `LDC_CMD_WORD_IDX + 16) begin : g_cmd_lane_chk
		$error("Command field must sit in the two upper byte lanes");
	end

	if (`LDC_FAULT_MASK_BIT >= `LDC_CMD_LSB) begin : g_mask_chk
		$error("Fault mask must lie below the command field");
	end

	if (`LDC_CORR_BITS != 7) begin : g_corr_width_chk
		$error("Correction fields must match the seven-bit type");
	end

	if (`LDC_CORR_STEP != 3 * `LDC_CORR_BITS) begin : g_step_chk
		$error("Correction triplet must hold three fields");
	end

	if (`LDC_BLUE_CORR0_LSB + 7 * `LDC_CORR_STEP + `LDC_CORR_BITS >
		`LDC_RED_BRIGHT_LSB) begin : g_corr_top_chk
		$error("Corrections must stay below the brightness fields");
	end

	// ****************************************************************
	// Constants and helpers
	// ****************************************************************
	localparam logic [`LDC_WORD_BITS-1:0] WORD_RST =
		{{(`LDC_WORD_BITS-1-`LDC_FAULT_MASK_BIT){1'b0}},
		`LDC_FAULT_MASK_RST,
		{(`LDC_FAULT_MASK_BIT){1'b0}}};

	function automatic logic [31:0] merge_lanes(
		input logic [31:0] old_w,
		input logic [31:0] new_w,
		input logic [3:0] strb
	);
		logic [31:0] m;
		m = old_w;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				m[b*8 +: 8] = new_w[b*8 +: 8];
			end
		end
		return m;
	endfunction

	function automatic logic [31:0] word_at(
		input logic [`LDC_WORD_BITS-1:0] w,
		input logic [3:0] idx
	);
		logic [31:0] r;
		r = 32'h0000_0000;
		for (int i = 0; i < `LDC_BUS_WORDS; i++) begin
			if (idx == i[3:0]) begin
				r = w[i*32 +: 32];
			end
		end
		return r;
	endfunction

	function automatic int blue_corr_lsb(input int ch);
		return `LDC_BLUE_CORR0_LSB + ch * `LDC_CORR_STEP;
	endfunction

	function automatic int red_corr_lsb(input int ch);
		return `LDC_RED_CORR0_LSB + ch * `LDC_CORR_STEP;
	endfunction

	// ****************************************************************
	// APB decode
	// ****************************************************************
	logic [`LDC_WORD_BITS-1:0] word_r;
	logic [`LDC_WORD_BITS-1:0] word_nxt;
	logic [31:0] prdata_r;
	logic [1:0] negate_r;
	logic [1:0] negate_nxt;
	ldc_readback_t readback_r;
	ldc_readback_t readback_nxt;
	ldc_cmd_pulse_t cmd_pulse;
	ldc_cmd_kind_t last_kind;

	wire [3:0] word_idx = paddr[5:2];
	wire high_zero = (paddr[ADDR_W-1:6] == '0);
	wire hit_word = high_zero && (word_idx < 4'(`LDC_BUS_WORDS));
	wire hit_status = high_zero && (word_idx == `LDC_STATUS_IDX);
	wire mapped = hit_word || hit_status;
	wire setup_ph = psel && !penable;
	wire access_ph = psel && penable;
	wire word_wr = access_ph && pwrite && hit_word;
	wire cmd_wr = word_wr && (word_idx == `LDC_CMD_WORD_IDX) &&
		(pstrb[3:2] != 2'b00);
	wire [31:0] status_w = {24'h00_0000, 4'(last_kind),
		2'(readback_r), negate_r};
	wire [31:0] read_mux = hit_word ? word_at(word_r, word_idx) :
		(hit_status ? status_w : 32'h0000_0000);

	assign pready = 1'b1;
	assign pslverr = access_ph && !mapped;

	// ****************************************************************
	// Configuration word
	// ****************************************************************
	always_comb begin
		word_nxt = word_r;
		if (cmd_pulse.global_reset) begin
			word_nxt = WORD_RST;
		end else if (word_wr) begin
			for (int i = 0; i < `LDC_BUS_WORDS; i++) begin
				if (word_idx == i[3:0]) begin
					word_nxt[i*32 +: 32] =
						merge_lanes(word_r[i*32 +: 32], pwdata, pstrb);
				end
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			word_r <= WORD_RST;
		end else begin
			word_r <= word_nxt;
		end
	end

	// ****************************************************************
	// Command decode
	// ****************************************************************
	ldc_cmd_decode u_decode (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.cmd_valid(cmd_wr),
		.cmd_code(word_nxt[`LDC_CMD_MSB:`LDC_CMD_LSB]),
		.last_kind(last_kind),
		.pulse(cmd_pulse)
	);

	// ****************************************************************
	// Negate bits and readback target
	// ****************************************************************
	always_comb begin
		negate_nxt = negate_r;
		readback_nxt = readback_r;
		if (cmd_pulse.global_reset) begin
			negate_nxt = `LDC_NEGATE_RST;
			readback_nxt = RB_NONE;
		end else begin
			if (cmd_pulse.negate_toggle) begin
				negate_nxt = ~negate_r;
			end
			if (cmd_pulse.read_select) begin
				readback_nxt = cmd_pulse.read_target;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			negate_r <= `LDC_NEGATE_RST;
			readback_r <= RB_NONE;
		end else begin
			negate_r <= negate_nxt;
			readback_r <= readback_nxt;
		end
	end

	// ****************************************************************
	// Read data capture in setup cycle
	// ****************************************************************
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			prdata_r <= 32'h0000_0000;
		end else if (setup_ph && !pwrite) begin
			prdata_r <= read_mux;
		end
	end

	assign prdata = prdata_r;

	// ****************************************************************
	// Field outputs
	// ****************************************************************
	always_comb begin
		cfg = '0;
		cfg.led_fault_mask = word_r[`LDC_FAULT_MASK_BIT];
		cfg.output_slew_slow = word_r[`LDC_SLEW_BIT];
		cfg.open_detect_level = word_r[`LDC_OPEN_LEVEL_BIT];
		cfg.short_detect_level = word_r[`LDC_SHORT_LEVEL_BIT];
		cfg.neighbour_short_test_current =
			word_r[`LDC_NPS_CURRENT_BIT];
		cfg.neighbour_short_test_duration =
			word_r[`LDC_NPS_DURATION_BIT];
		cfg.grayscale_width_select =
			word_r[`LDC_GS_WIDTH_MSB:`LDC_GS_WIDTH_LSB];
		unique case (cfg.grayscale_width_select)
			2'h2: cfg.grayscale_counter_bits = 4'hA;
			2'h3: cfg.grayscale_counter_bits = 4'h8;
			default: cfg.grayscale_counter_bits = 4'hC;
		endcase
		cfg.display_timing_reset = word_r[`LDC_TIMING_RESET_BIT];
		cfg.auto_repeat = word_r[`LDC_AUTO_REPEAT_BIT];
		cfg.blue_group_correction_range =
			word_r[`LDC_BLUE_RANGE_BIT];
		cfg.red_group_correction_range = word_r[`LDC_RED_RANGE_BIT];
		cfg.blue_group_brightness =
			word_r[`LDC_BLUE_BRIGHT_MSB:`LDC_BLUE_BRIGHT_LSB];
		cfg.red_group_brightness =
			word_r[`LDC_RED_BRIGHT_MSB:`LDC_RED_BRIGHT_LSB];
		for (int ch = 0; ch < 8; ch++) begin
			cfg.blue_correction[ch] =
				word_r[blue_corr_lsb(ch) +: `LDC_CORR_BITS];
			cfg.red_correction[ch] =
				word_r[red_corr_lsb(ch) +: `LDC_CORR_BITS];
		end
	end

	assign negate_check_bit = negate_r;
	assign readback_select = readback_r;
	assign detector_self_test_start = cmd_pulse.self_test;
	assign neighbour_pin_short_start = cmd_pulse.neighbour_pin_short;
	assign error_clear = cmd_pulse.error_clear;
	assign global_reset = cmd_pulse.global_reset;

endmodule

// ### rtl/ldc_defs.svh
`ifndef LDC_DEFS_SVH
`define LDC_DEFS_SVH

// ****************************************************************
// Word geometry and bus map
// ****************************************************************
`define LDC_WORD_BITS 288
`define LDC_BUS_WORDS 9
`define LDC_CMD_WORD_IDX 4'h8
`define LDC_STATUS_IDX 4'h9
`define LDC_CFG_BASE 8'h00
`define LDC_STATUS_OFS 8'h24

// ****************************************************************
// Command field and codes
// ****************************************************************
`define LDC_CMD_MSB 287
`define LDC_CMD_LSB 276
`define LDC_CODE_GLOBAL_RESET 12'h25C
`define LDC_CODE_SELF_TEST 12'h535
`define LDC_CODE_NEIGHBOUR_SHORT 12'h53A
`define LDC_CODE_NEGATE_TOGGLE 12'h55A
`define LDC_CODE_READ_STATUS 12'h5A3
`define LDC_CODE_READ_CONFIG 12'h5AC
`define LDC_CODE_READ_GRAYSCALE 12'h5AF
`define LDC_CODE_ERROR_CLEAR 12'hA53

// ****************************************************************
// Function control bit positions
// ****************************************************************
`define LDC_FAULT_MASK_BIT 204
`define LDC_SLEW_BIT 203
`define LDC_OPEN_LEVEL_BIT 202
`define LDC_SHORT_LEVEL_BIT 201
`define LDC_NPS_CURRENT_BIT 200
`define LDC_NPS_DURATION_BIT 199
`define LDC_GS_WIDTH_MSB 198
`define LDC_GS_WIDTH_LSB 197
`define LDC_TIMING_RESET_BIT 196
`define LDC_AUTO_REPEAT_BIT 195
`define LDC_BLUE_RANGE_BIT 194
`define LDC_RED_RANGE_BIT 192
`define LDC_BLUE_BRIGHT_MSB 191
`define LDC_BLUE_BRIGHT_LSB 184
`define LDC_RED_BRIGHT_MSB 175
`define LDC_RED_BRIGHT_LSB 168

// ****************************************************************
// Per-channel correction layout
// ****************************************************************
`define LDC_CORR_BITS 7
`define LDC_CORR_STEP 21
`define LDC_BLUE_CORR0_LSB 14
`define LDC_RED_CORR0_LSB 0

// ****************************************************************
// Reset values
// ****************************************************************
`define LDC_FAULT_MASK_RST 1'b1
`define LDC_NEGATE_RST 2'h0

`endif

// ### rtl/ldc_pkg.sv
package ldc_pkg;

	typedef enum logic [3:0] {
		CMD_NULL,
		CMD_GLOBAL_RESET,
		CMD_SELF_TEST,
		CMD_NEIGHBOUR_SHORT,
		CMD_NEGATE_TOGGLE,
		CMD_READ_STATUS,
		CMD_READ_CONFIG,
		CMD_READ_GRAYSCALE,
		CMD_ERROR_CLEAR
	} ldc_cmd_kind_t;

	typedef enum logic [1:0] {
		RB_NONE,
		RB_STATUS,
		RB_CONFIG,
		RB_GRAYSCALE
	} ldc_readback_t;

	typedef struct packed {
		logic global_reset;
		logic self_test;
		logic neighbour_pin_short;
		logic negate_toggle;
		logic error_clear;
		logic read_select;
		ldc_readback_t read_target;
	} ldc_cmd_pulse_t;

	typedef struct packed {
		logic led_fault_mask;
		logic output_slew_slow;
		logic open_detect_level;
		logic short_detect_level;
		logic neighbour_short_test_current;
		logic neighbour_short_test_duration;
		logic [1:0] grayscale_width_select;
		logic [3:0] grayscale_counter_bits;
		logic display_timing_reset;
		logic auto_repeat;
		logic blue_group_correction_range;
		logic red_group_correction_range;
		logic [7:0] blue_group_brightness;
		logic [7:0] red_group_brightness;
		logic [7:0][6:0] blue_correction;
		logic [7:0][6:0] red_correction;
	} ldc_cfg_t;

endpackage

// ### test/ldc_config_regs_assertions.sv
`timescale 1ns/10ps
module ldc_config_regs_chk
	import ldc_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire ldc_cfg_t cfg,
	input wire logic [1:0] negate_check_bit,
	input wire ldc_readback_t readback_select,
	input wire logic detector_self_test_start,
	input wire logic neighbour_pin_short_start,
	input wire logic error_clear,
	input wire logic global_reset
);
	logic acc;
	logic cw;
	logic known;
	logic [11:0] code;
	logic [3:0] gs_bits;
	assign acc = psel && penable;
	assign cw = acc && pwrite && paddr == 'h20 && pstrb[3:2] == 2'b11;
	assign code = pwdata[31:20];
	assign known = code inside {12'h25C, 12'h535, 12'h53A, 12'h55A,
		12'h5A3, 12'h5AC, 12'h5AF, 12'hA53};
	assign gs_bits = cfg.grayscale_width_select == 2'h3 ? 4'h8 :
		cfg.grayscale_width_select == 2'h2 ? 4'hA : 4'hC;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// ****************************************************************
	// Bus, command and counter width decode checks
	// ****************************************************************
	a_ready_high: assert property (pready)
		else $error("pready low");
	a_err_unmapped: assert property (acc |-> pslverr == ((paddr >> 2) > 9))
		else $error("pslverr wrong for address");
	a_reset_cmd: assert property (cw && code == 12'h25C |=> global_reset
		##1 (cfg.led_fault_mask && cfg.red_group_brightness == 8'h00))
		else $error("global reset command failed");
	a_clear_cmd: assert property (cw && code == 12'hA53 |=> error_clear)
		else $error("error clear pulse missing");
	a_null_cmd: assert property (cw && !known |=> !(global_reset
		|| error_clear || detector_self_test_start
		|| neighbour_pin_short_start))
		else $error("undefined code had an effect");
	a_test_cmd: assert property (cw && code == 12'h535
		|=> detector_self_test_start && !neighbour_pin_short_start)
		else $error("self test pulse missing");
	a_short_cmd: assert property (cw && code == 12'h53A
		|=> neighbour_pin_short_start)
		else $error("short check pulse missing");
	a_negate_cmd: assert property (cw && code == 12'h55A
		|-> ##2 negate_check_bit == ~$past(negate_check_bit, 2))
		else $error("negate bits not toggled");
	a_read_sel: assert property (cw && code == 12'h5AC
		|-> ##2 readback_select == RB_CONFIG)
		else $error("readback select wrong");
	a_gs_decode: assert property (cfg.grayscale_counter_bits == gs_bits)
		else $error("counter width decode wrong");
	c_reset_cmd: cover property (cw && code == 12'h25C);
	c_unmapped: cover property (acc && pslverr);
	c_negate: cover property (cw && code == 12'h55A);
endmodule
bind ldc_config_regs ldc_config_regs_chk #(.ADDR_W(ADDR_W))
	ldc_config_regs_chk_inst (.sys_clk(sys_clk), .resetn(resetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .cfg(cfg), .negate_check_bit(negate_check_bit),
	.readback_select(readback_select),
	.detector_self_test_start(detector_self_test_start),
	.neighbour_pin_short_start(neighbour_pin_short_start),
	.error_clear(error_clear), .global_reset(global_reset));

// ### test/ldc_host.sv
`timescale 1ns/10ps
module ldc_host (
	input wire logic sys_clk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'hFF;
		pwdata = 32'h00000000;
		pstrb = 4'h0;
	end
	// Setup, access until pready, release, one idle edge
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] r, output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) @(posedge sys_clk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
		pstrb <= 4'h0;
		@(posedge sys_clk);
	endtask
endmodule

// ### test/led_driver_command_config_register_tb.sv
`timescale 1ns/10ps
module led_driver_command_config_register_tb;
	import ldc_pkg::*;
	logic sys_clk, resetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [3:0] pstrb;
	logic e;
	logic self_test_p, short_test_p, error_clear_p, global_reset_p;
	int pulse_count [4] = '{0, 0, 0, 0};
	ldc_cfg_t cfg;
	logic [1:0] negate_check_bit;
	ldc_readback_t readback_select;
	int errors, checks_done, i;
	logic [3:0] gsw [4] = '{4'hC, 4'hC, 4'hA, 4'h8};
	logic [11:0] codes [6] = '{12'h5A3, 12'h5AC, 12'h5AF,
		12'h535, 12'h53A, 12'hA53};
	logic [7:0] kinds [3] = '{8'h2C, 8'h3C, 8'h8C};
	ldc_host ldc_host_inst (.sys_clk(sys_clk), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	ldc_config_regs ldc_config_regs_inst (.sys_clk(sys_clk),
		.resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cfg(cfg),
		.negate_check_bit(negate_check_bit),
		.readback_select(readback_select),
		.detector_self_test_start(self_test_p),
		.neighbour_pin_short_start(short_test_p),
		.error_clear(error_clear_p), .global_reset(global_reset_p));
	// Pulse cycles per command output
	always @(posedge sys_clk) begin
		if (self_test_p === 1'b1) pulse_count[0] <= pulse_count[0] + 1;
		if (short_test_p === 1'b1) pulse_count[1] <= pulse_count[1] + 1;
		if (error_clear_p === 1'b1) pulse_count[2] <= pulse_count[2] + 1;
		if (global_reset_p === 1'b1) pulse_count[3] <= pulse_count[3] + 1;
	end
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		checks_done++;
		if (g !== x) begin
			errors++;
			$display("ERROR t=%0t got %h exp %h", $time, g, x);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ldc_host_inst.xfer(1'b1, a, d, 4'hF, r, e);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] x);
		ldc_host_inst.xfer(1'b0, a, 32'h00000000, 4'h0, r, e);
		chk(r, x);
		chk(32'(e), 32'h00000000);
	endtask
	task automatic cmd(input logic [11:0] c);
		wr(8'h20, {c, 20'h00000});
		@(posedge sys_clk);
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#100000;
		errors++;
		end_of_test;
	end
	initial begin
		resetn = 1'b0;
		errors = 0;
		checks_done = 0;
		repeat (4) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		for (i = 0; i < 9; i++) rchk(8'(4 * i), i == 6 ? 32'h1000 : 0);
		chk(32'(cfg.led_fault_mask), 32'h00000001);
		$display("reset test done");
		wr(8'h00, 32'h001FC07F);
		wr(8'h10, 32'h03F80000);
		wr(8'h14, 32'hA5005AFE);
		chk(32'(cfg.red_correction[0]), 32'h0000007F);
		chk(32'(cfg.blue_correction[0]), 32'h0000007F);
		chk(32'(cfg.red_correction[7]), 32'h0000007F);
		chk(32'(cfg.blue_correction[7]), 32'h0000007F);
		chk(32'(cfg.blue_group_brightness), 32'h000000A5);
		chk(32'(cfg.red_group_brightness), 32'h0000005A);
		rchk(8'h14, 32'hA5005AFE);
		for (i = 0; i < 4; i++) begin
			wr(8'h18, {19'h0, i[0], 3'h0, i[0], i[1], i[1:0], 2'h0,
				i[0], 1'b0, ~i[0]});
			chk(32'(cfg.led_fault_mask), 32'(i[0]));
			chk(32'(cfg.neighbour_short_test_current), 32'(i[0]));
			chk(32'(cfg.neighbour_short_test_duration), 32'(i[1]));
			chk(32'(cfg.grayscale_counter_bits), 32'(gsw[i]));
			chk(32'(cfg.blue_group_correction_range), 32'(i[0]));
			chk(32'(cfg.red_group_correction_range), 32'(!i[0]));
		end
		rchk(8'h18, 32'h000011E4);
		$display("field test done");
		cmd(12'h55A);
		chk(32'(negate_check_bit), 32'h00000003);
		cmd(12'h55A);
		chk(32'(negate_check_bit), 32'h00000000);
		for (i = 0; i < 3; i++) begin
			cmd(codes[i]);
			chk(32'(readback_select), 32'(i + 1));
		end
		cmd(12'h123);
		rchk(8'h24, 32'h0000000C);
		for (i = 0; i < 3; i++) begin
			cmd(codes[i + 3]);
			rchk(8'h24, 32'(kinds[i]));
		end
		cmd(12'h55A);
		cmd(12'h25C);
		chk(32'(pulse_count[0]), 32'h00000001);
		chk(32'(pulse_count[1]), 32'h00000001);
		chk(32'(pulse_count[2]), 32'h00000001);
		chk(32'(pulse_count[3]), 32'h00000001);
		rchk(8'h14, 32'h00000000);
		rchk(8'h18, 32'h00001000);
		rchk(8'h20, 32'h00000000);
		rchk(8'h24, 32'h00000010);
		$display("command test done");
		ldc_host_inst.xfer(1'b0, 8'h28, 32'h0, 4'h0, r, e);
		chk(r, 32'h00000000);
		chk(32'(e), 32'h00000001);
		wr(8'h40, 32'hFFFFFFFF);
		rchk(8'h00, 32'h00000000);
		$display("unmapped test done");
		end_of_test;
	end
endmodule
